/* dmiu_asserts.sv */
// Port-level timing checks for the data-move unit.
// Assumes a bind onto dmiu_core, single clock domain.
`timescale 1ns/100ps
module dmiu_asserts (
   input logic sys_clk,
   input logic nrst,
   input logic instr_valid,
   input logic [47:0] instr,
   input logic [7:0] working_segment,
   input logic ready_q,
   input logic done_q,
   input logic illegal_q,
   input logic mem_rd_q,
   input logic mem_wr_q,
   input logic mem_word_q,
   input logic [23:0] mem_addr_q,
   input logic neg_flag_q,
   input logic zero_flag_q
);
   // Take and opcode decode helpers
   logic take;
   logic g8;
   logic [2:0] md;
   assign take = ready_q && instr_valid;
   assign g8 = take && (instr[47:44] == 4'h8);
   assign md = instr[42:40];

   //----------------------------------------------------------------
   // Properties
   //----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   AST_BUSY: assert property (take |=> !ready_q [*2])
      else $error("ready not dropped after take");
   AST_RR_CLK: assert property (g8 && md == 3'h1 |-> ##2 done_q)
      else $error("register move count wrong");
   AST_IND_CLK: assert property (g8 && md == 3'h2 |-> ##2 done_q)
      else $error("indirect move count wrong");
   AST_INC_CLK: assert property (g8 && md == 3'h3 |-> ##3 done_q)
      else $error("post-increment count wrong");
   AST_OFF_CLK: assert property (g8 && (md == 3'h4 || md == 3'h5)
      |-> ##4 done_q)
      else $error("offset move count wrong");
   AST_MEM_C1: assert property (g8 && md >= 3'h2 && md <= 3'h6
      |=> mem_rd_q || mem_wr_q)
      else $error("no memory access in cycle one");
   AST_NO_MEM: assert property (g8 && md == 3'h1
      |=> !(mem_rd_q || mem_wr_q) [*2])
      else $error("register move touched memory");
   AST_SIZE: assert property (g8 && md >= 3'h2 && md <= 3'h6
      |=> mem_word_q == $past(instr[43]))
      else $error("access width wrong");
   AST_DIRECT: assert property (g8 && md == 3'h6 |=> mem_addr_q ==
      {13'h0000, $past(instr[34:32]), $past(instr[31:24])})
      else $error("direct address wrong");
   AST_SEG: assert property (g8 && md == 3'h2
      |=> mem_addr_q[23:16] == $past(working_segment))
      else $error("segment wrong");
   AST_ILL: assert property (illegal_q |-> done_q)
      else $error("illegal without done");
   AST_DONE: assert property (done_q |=> ready_q && !done_q)
      else $error("done not one cycle before ready");
   AST_FLAGS: assert property (ready_q && !instr_valid
      |=> $stable({neg_flag_q, zero_flag_q}))
      else $error("flags moved while idle");

   // Main scenarios reached
   cover property (g8 && md == 3'h1);
   cover property (g8 && md == 3'h3);
   cover property (illegal_q);
endmodule

bind dmiu_core dmiu_asserts i_chk (.*);

/* dmiu_core.v */
// Data-move instruction unit: decodes and executes one move at a time.
// Assumes a same-clock data memory answering reads in the request cycle.
//
// Contract
// RULE1: copy the selected byte or word to destination, source left intact
// RULE2: operands may be register, pointer, pointer plus offset, or direct
// RULE3: immediate data is accepted as source only, never as destination
// RULE4: post-increment exists only for plain pointer-indirect forms
// RULE5: register-to-register form is 1000 size 001, two bytes, three clocks
// RULE6: store through destination pointer takes two bytes, three clocks
// RULE7: load from pointer plus offset8: three bytes, offset third, five clocks
// RULE8: store to pointer plus offset8: three bytes, five clocks
// RULE9: offset16 forms: four bytes, five clocks, upper byte then lower byte
// RULE10: post-increment load writes register then adds one or two to pointer
// RULE11: post-increment store writes memory, adds one or two, four clocks
// RULE12: direct address is three bits of byte two plus byte three
// RULE13: immediate byte at pointer plus offset8: offset, data, five clocks
// RULE14: immediate word at pointer plus offset8: offset, upper, lower byte
// RULE15: immediate word post-increment: lower byte fourth, pointer plus two
// RULE16: every move sets negative and zero from moved value, others kept
// RULE17: size bit clear means byte move, set means word move
`include "dmiu_defs.vh"
`timescale 1ns/100ps
module dmiu_core (
   input wire sys_clk,
   input wire nrst,
   input wire instr_valid,
   input wire [47:0] instr,
   input wire [7:0] working_segment,
   input wire [15:0] mem_rdata,
   input wire preload_en,
   input wire [3:0] preload_idx,
   input wire [15:0] preload_data,
   output reg ready_q,
   output reg done_q,
   output reg illegal_q,
   output reg mem_rd_q,
   output reg mem_wr_q,
   output reg mem_word_q,
   output reg [23:0] mem_addr_q,
   output reg [15:0] mem_wdata_q,
   output reg neg_flag_q,
   output reg zero_flag_q,
   output reg rf_wr_q,
   output reg [3:0] rf_wr_idx_q,
   output reg [1:0] rf_wr_be_q,
   output reg [15:0] rf_wr_data_q
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Instruction byte k, byte 1 in the top bits
   function [7:0] dmiu_byte;
      input [47:0] v;
      input [2:0] k;
      begin
         case (k)
            3'h1: dmiu_byte = v[47:40];
            3'h2: dmiu_byte = v[39:32];
            3'h3: dmiu_byte = v[31:24];
            3'h4: dmiu_byte = v[23:16];
            3'h5: dmiu_byte = v[15:8];
            3'h6: dmiu_byte = v[7:0];
            default: dmiu_byte = 8'h00;
         endcase
      end
   endfunction

   // Word-register index and byte enables for a sized register number
   function [5:0] dmiu_rsel;
      input word;
      input [3:0] r;
      begin
         if (word)
            dmiu_rsel = {r, 2'h3};
         else
            dmiu_rsel = {1'b0, r[3:1], r[0], ~r[0]};
      end
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg [1:0] st_q;
   reg [1:0] kind_q;
   reg sz_q;
   reg [3:0] dst_q;
   reg [2:0] ptr_q;
   reg inc_q;
   reg ill_q;
   reg [2:0] clk_q;
   reg [2:0] cnt_q;
   reg [15:0] val_q;

   reg [7:0] b1, b2, b3, b4;
   reg is_imm, sz, legal;
   reg [2:0] md;
   reg [1:0] dec_kind;
   reg [3:0] dec_src;
   reg [2:0] dec_ptr;
   reg [2:0] dec_clk;
   reg [2:0] ipos;
   reg [15:0] dec_imm, dec_val, dec_addr, dec_off;
   reg [5:0] rsel;

   reg wr_en;
   reg [3:0] wr_idx;
   reg [1:0] wr_be;
   reg [15:0] wr_data;
   reg [15:0] mv;
   reg [5:0] wsel;

   wire [15:0] ra_data;
   wire [15:0] rb_data;
   wire take = ready_q && instr_valid;
   wire [3:0] rb_idx = (st_q == `DMIU_ST_IDLE) ? {1'b0, dec_ptr}
                                                : {1'b0, ptr_q};

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   always @*
   begin
      b1 = dmiu_byte(instr, 3'h1);
      b2 = dmiu_byte(instr, 3'h2);
      b3 = dmiu_byte(instr, 3'h3);
      b4 = dmiu_byte(instr, 3'h4);
      is_imm = (b1[7:4] == `DMIU_GRP_IMM);
      sz = b1[`DMIU_SZ_BIT]; // RULE17
      md = b1[2:0];
      // Immediate group needs the tag; imm never lands as destination
      legal = (md >= `DMIU_MD_RR) && (md <= `DMIU_MD_DIR) &&
              ((b1[7:4] == `DMIU_GRP_REG) ||
               (is_imm && (b2[3:0] == `DMIU_IMM_TAG) &&
                ((md == `DMIU_MD_RR) || !b2[7]))); // RULE3
      // Kind of move
      if (!legal)
         dec_kind = `DMIU_K_NONE;
      else if (md == `DMIU_MD_RR)
         dec_kind = `DMIU_K_REG; // RULE5
      else if (is_imm || b2[`DMIU_DIR_BIT])
         dec_kind = `DMIU_K_STORE; // RULE6
      else
         dec_kind = `DMIU_K_LOAD; // RULE2
      dec_src = (!is_imm && md == `DMIU_MD_RR) ? b2[3:0] : b2[7:4];
      dec_ptr = is_imm ? b2[6:4] : b2[2:0];
      // Clock count per form
      case (md)
         `DMIU_MD_RR: dec_clk = `DMIU_CLK_RR;
         `DMIU_MD_IND: dec_clk = `DMIU_CLK_IND;
         `DMIU_MD_INC: dec_clk = `DMIU_CLK_INC; // RULE11
         `DMIU_MD_OFF8: dec_clk = `DMIU_CLK_OFF; // RULE7 RULE8 RULE13
         `DMIU_MD_OFF16: dec_clk = `DMIU_CLK_OFF; // RULE9
         `DMIU_MD_DIR: dec_clk = is_imm ? `DMIU_CLK_DIR_IMM : `DMIU_CLK_DIR;
         default: dec_clk = `DMIU_CLK_ILL;
      endcase
      if (!legal)
         dec_clk = `DMIU_CLK_ILL;
      // Offset: signed byte three, or upper byte three and lower byte four
      case (md)
         `DMIU_MD_OFF8: dec_off = {{8{b3[7]}}, b3}; // RULE7
         `DMIU_MD_OFF16: dec_off = {b3, b4}; // RULE9
         default: dec_off = 16'h0000;
      endcase
      if (md == `DMIU_MD_DIR)
         dec_addr = {5'h00, is_imm ? b2[6:4] : b2[2:0], b3}; // RULE12
      else
         dec_addr = rb_data + dec_off; // RULE2
      // Immediate position follows offset bytes
      case (md)
         `DMIU_MD_OFF8: ipos = 3'h4; // RULE13 RULE14
         `DMIU_MD_OFF16: ipos = 3'h5;
         `DMIU_MD_DIR: ipos = 3'h4;
         default: ipos = 3'h3; // RULE15
      endcase
      if (sz)
         dec_imm = {dmiu_byte(instr, ipos),
                    dmiu_byte(instr, ipos + 3'h1)}; // RULE14
      else
         dec_imm = {8'h00, dmiu_byte(instr, ipos)};
      // Source register value, sized
      rsel = dmiu_rsel(sz, dec_src);
      if (sz)
         dec_val = ra_data;
      else if (dec_src[0])
         dec_val = {8'h00, ra_data[15:8]};
      else
         dec_val = {8'h00, ra_data[7:0]};
      if (is_imm)
         dec_val = dec_imm; // RULE3
   end

   // ------------------------------------------------------------
   // Register write port
   // ------------------------------------------------------------
   always @*
   begin
      mv = (kind_q == `DMIU_K_LOAD) ? mem_rdata : val_q;
      if (!sz_q)
         mv = {8'h00, mv[7:0]};
      wsel = dmiu_rsel(sz_q, dst_q);
      wr_en = 1'b0;
      wr_idx = 4'h0;
      wr_be = 2'h0;
      wr_data = 16'h0000;
      if (st_q == `DMIU_ST_IDLE && preload_en)
      begin
         wr_en = 1'b1;
         wr_idx = preload_idx;
         wr_be = 2'h3;
         wr_data = preload_data;
      end
      else if (st_q == `DMIU_ST_EXEC && cnt_q == 3'h1 &&
               (kind_q == `DMIU_K_LOAD || kind_q == `DMIU_K_REG))
      begin
         wr_en = 1'b1; // RULE1
         wr_idx = wsel[5:2];
         wr_be = wsel[1:0];
         wr_data = sz_q ? mv : {mv[7:0], mv[7:0]};
      end
      else if (st_q == `DMIU_ST_EXEC && cnt_q == 3'h2 && inc_q)
      begin
         // Pointer advance after the access
         wr_en = 1'b1; // RULE10 RULE11
         wr_idx = {1'b0, ptr_q};
         wr_be = 2'h3;
         wr_data = rb_data + (sz_q ? 16'h0002 : 16'h0001); // RULE15
      end
   end

   dmiu_regfile u_rf (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .wr_en(wr_en),
      .wr_idx(wr_idx),
      .wr_be(wr_be),
      .wr_data(wr_data),
      .ra_idx(rsel[5:2]),
      .rb_idx(rb_idx),
      .ra_data(ra_data),
      .rb_data(rb_data)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Take, access, writeback, pointer advance, done, back to idle
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= `DMIU_ST_IDLE;
         kind_q <= `DMIU_K_NONE;
         sz_q <= 1'b0;
         dst_q <= 4'h0;
         ptr_q <= 3'h0;
         inc_q <= 1'b0;
         ill_q <= 1'b0;
         clk_q <= `DMIU_CLK_ILL;
         cnt_q <= 3'h0;
         val_q <= 16'h0000;
         ready_q <= 1'b1;
         done_q <= 1'b0;
         illegal_q <= 1'b0;
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_word_q <= 1'b0;
         mem_addr_q <= 24'h000000;
         mem_wdata_q <= 16'h0000;
         neg_flag_q <= 1'b0;
         zero_flag_q <= 1'b0;
         rf_wr_q <= 1'b0;
         rf_wr_idx_q <= 4'h0;
         rf_wr_be_q <= 2'h0;
         rf_wr_data_q <= 16'h0000;
      end
      else
      begin
         rf_wr_q <= wr_en;
         rf_wr_idx_q <= wr_idx;
         rf_wr_be_q <= wr_be;
         rf_wr_data_q <= wr_data;
         done_q <= 1'b0;
         illegal_q <= 1'b0;
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         case (st_q)
            `DMIU_ST_IDLE:
            begin
               if (take)
               begin
                  st_q <= `DMIU_ST_EXEC;
                  ready_q <= 1'b0;
                  cnt_q <= 3'h1;
                  kind_q <= dec_kind;
                  sz_q <= sz;
                  dst_q <= b2[7:4];
                  ptr_q <= dec_ptr;
                  inc_q <= legal && (md == `DMIU_MD_INC); // RULE4
                  ill_q <= !legal;
                  clk_q <= dec_clk;
                  val_q <= dec_val;
                  mem_word_q <= sz;
                  mem_wdata_q <= dec_val;
                  mem_rd_q <= (dec_kind == `DMIU_K_LOAD);
                  mem_wr_q <= (dec_kind == `DMIU_K_STORE); // RULE6
                  if (md == `DMIU_MD_DIR)
                     mem_addr_q <= {`DMIU_DIR_SEG, dec_addr}; // RULE12
                  else
                     mem_addr_q <= {working_segment, dec_addr};
               end
            end
            `DMIU_ST_EXEC:
            begin
               if (cnt_q == 3'h1 && kind_q != `DMIU_K_NONE)
               begin
                  // Flags from the value moved
                  neg_flag_q <= sz_q ? mv[15] : mv[7]; // RULE16
                  zero_flag_q <= sz_q ? (mv == 16'h0000)
                                      : (mv[7:0] == 8'h00); // RULE16
               end
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == clk_q - 3'h2)
               begin
                  st_q <= `DMIU_ST_DONE; // RULE5 RULE7 RULE9
                  done_q <= 1'b1;
                  illegal_q <= ill_q;
               end
            end
            `DMIU_ST_DONE:
            begin
               st_q <= `DMIU_ST_IDLE;
               ready_q <= 1'b1;
            end
            default:
            begin
               st_q <= `DMIU_ST_IDLE;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

endmodule

/* dmiu_defs.vh */
// Constants for the data-move instruction unit.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DMIU_DEFS_VH
`define DMIU_DEFS_VH

// Opcode groups in the high nibble of the first instruction byte
`define DMIU_GRP_REG 4'h8
`define DMIU_GRP_IMM 4'h9
// Low nibble of the second byte that tags the immediate group
`define DMIU_IMM_TAG 4'h8

// Addressing modes in the low three bits of the first byte
`define DMIU_MD_RR 3'h1
`define DMIU_MD_IND 3'h2
`define DMIU_MD_INC 3'h3
`define DMIU_MD_OFF8 3'h4
`define DMIU_MD_OFF16 3'h5
`define DMIU_MD_DIR 3'h6

// Field positions
`define DMIU_SZ_BIT 3
`define DMIU_DIR_BIT 3

// Clock counts per form
`define DMIU_CLK_RR 3'h3
`define DMIU_CLK_IND 3'h3
`define DMIU_CLK_INC 3'h4
`define DMIU_CLK_OFF 3'h5
`define DMIU_CLK_DIR 3'h4
`define DMIU_CLK_DIR_IMM 3'h3
`define DMIU_CLK_ILL 3'h3

// Execution states
`define DMIU_ST_IDLE 2'h0
`define DMIU_ST_EXEC 2'h1
`define DMIU_ST_DONE 2'h2

// Operation kinds
`define DMIU_K_NONE 2'h0
`define DMIU_K_LOAD 2'h1
`define DMIU_K_STORE 2'h2
`define DMIU_K_REG 2'h3

// Reset values and segment used for direct addresses
`define DMIU_RST_WORD 16'h0000
`define DMIU_DIR_SEG 8'h00

`endif

/* dmiu_mem_model.sv */
// Data memory answering reads in the request cycle.
// Assumes mem_addr_q and mem_rd_q from dmiu_core on sys_clk.
`timescale 1ns/100ps
module dmiu_mem_model (
   input wire sys_clk,
   input wire mem_rd_q,
   input wire [23:0] mem_addr_q,
   output wire [15:0] mem_rdata
);
   reg tog_q;
   initial tog_q = 1'b0;

   // Changing junk while no read is asked
   always @(posedge sys_clk)
   begin
      tog_q <= ~tog_q;
   end

   // Read data is a pattern of the address
   assign mem_rdata = mem_rd_q ? {mem_addr_q[7:0] ^ 8'hA5, mem_addr_q[7:0]}
      : {16{tog_q}};
endmodule

/* dmiu_regfile.v */
// Sixteen-word register file for the data-move unit.
// Assumes one write port with byte enables, two combinational read ports.
`include "dmiu_defs.vh"
`timescale 1ns/100ps
module dmiu_regfile (
   input wire sys_clk,
   input wire nrst,
   input wire wr_en,
   input wire [3:0] wr_idx,
   input wire [1:0] wr_be,
   input wire [15:0] wr_data,
   input wire [3:0] ra_idx,
   input wire [3:0] rb_idx,
   output wire [15:0] ra_data,
   output wire [15:0] rb_data
);

   reg [15:0] word_q [0:15];

   // ------------------------------------------------------------
   // Storage rows
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1)
      begin : row
         // One row, each byte lane written on its own enable
         always @(posedge sys_clk or negedge nrst)
         begin
            if (!nrst)
               word_q[gi] <= `DMIU_RST_WORD;
            else if (wr_en && (wr_idx == gi))
            begin
               if (wr_be[0])
                  word_q[gi][7:0] <= wr_data[7:0];
               if (wr_be[1])
                  word_q[gi][15:8] <= wr_data[15:8];
            end
         end
      end
   endgenerate

   // Read ports
   assign ra_data = word_q[ra_idx];
   assign rb_data = word_q[rb_idx];

endmodule

/* tb_dmiu_core.sv */
// Self-checking bench for the data-move unit.
// Assumes dmiu_core, dmiu_mem_model and the bound checker.
`timescale 1ns/100ps
`define CHK(g, e) \
   begin \
      compares = compares + 1; \
      if ((g) !== (e)) \
      begin \
         fails = fails + 1; \
         $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end
module tb_dmiu_core;
   reg sys_clk, nrst, instr_valid, preload_en, g_ill, st;
   reg [47:0] instr;
   reg [3:0] preload_idx;
   reg [15:0] preload_data;
   reg [7:0] working_segment;
   wire [15:0] mem_rdata, mem_wdata_q, rf_wr_data_q;
   wire ready_q, done_q, illegal_q, mem_rd_q, mem_wr_q, mem_word_q;
   wire neg_flag_q, zero_flag_q, rf_wr_q;
   wire [23:0] mem_addr_q;
   wire [3:0] rf_wr_idx_q;
   wire [1:0] rf_wr_be_q;
   reg [23:0] g_a;
   reg [15:0] g_d, g_p;
   reg [3:0] g_n;
   reg [5:0] g_w;
   reg [1:0] fl;
   reg [109:0] tbl [0:15];
   reg [109:0] t;
   reg [15:0] pre [0:4];
   integer fails, compares, i;

   dmiu_core i_dut (.sys_clk, .nrst, .instr_valid, .instr,
      .working_segment, .mem_rdata, .preload_en, .preload_idx,
      .preload_data, .ready_q, .done_q, .illegal_q, .mem_rd_q, .mem_wr_q,
      .mem_word_q, .mem_addr_q, .mem_wdata_q, .neg_flag_q, .zero_flag_q,
      .rf_wr_q, .rf_wr_idx_q, .rf_wr_be_q, .rf_wr_data_q);
   dmiu_mem_model i_mem (.sys_clk, .mem_rd_q, .mem_addr_q, .mem_rdata);

   // 10 MHz clock
   always #50 sys_clk = ~sys_clk;

   task finish_test;
      begin
         $display("compares=%0d fails=%0d", compares, fails);
         if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   // Issue one move and record what it does up to done
   task run(input [47:0] ins);
      integer c;
      integer nrf;
      reg dn;
      begin
         c = 0;
         while (ready_q !== 1'b1 && c < 20)
         begin
            @(posedge sys_clk);
            #1;
            c = c + 1;
         end
         if (ready_q !== 1'b1)
         begin
            fails = fails + 1;
            finish_test;
         end
         instr = ins;
         instr_valid = 1'b1;
         @(posedge sys_clk);
         #1;
         instr_valid = 1'b0;
         g_a = 24'h0;
         g_d = 'x;
         g_p = 16'h0;
         g_w = 6'h00;
         st = 1'b0;
         nrf = 0;
         c = 0;
         dn = 1'b0;
         // Sample every cycle up to and including the done cycle
         while (!dn && c < 20)
         begin
            c = c + 1;
            dn = (done_q === 1'b1);
            if (mem_rd_q === 1'b1 || mem_wr_q === 1'b1)
               g_a = mem_addr_q;
            if (mem_wr_q === 1'b1)
            begin
               g_d = mem_wdata_q;
               st = 1'b1;
            end
            if (rf_wr_q === 1'b1)
            begin
               if (nrf == 0 && !st)
                  g_d = rf_wr_data_q;
               if (nrf == 0)
                  g_w = {rf_wr_idx_q, rf_wr_be_q};
               g_p = rf_wr_data_q;
               nrf = nrf + 1;
            end
            if (!dn)
            begin
               @(posedge sys_clk);
               #1;
            end
         end
         if (!dn)
         begin
            fails = fails + 1;
            finish_test;
         end
         g_n = c + 1;
         g_ill = illegal_q;
      end
   endtask

   //----------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      nrst = 1'b0;
      instr_valid = 1'b0;
      instr = 48'h0;
      preload_en = 1'b0;
      preload_idx = 4'h0;
      preload_data = 16'h0;
      working_segment = 8'h3C;
      fails = 0;
      compares = 0;
      pre[0] = 16'h1000;
      pre[1] = 16'h2040;
      pre[2] = 16'h80F0;
      pre[3] = 16'h0000;
      pre[4] = 16'h1234;
      // Rows: instr, clocks, address, data, pointer, {N,Z}
      tbl[0] = {48'h895200000000, 4'h3, 24'h0, 16'h80F0, 16'h0, 2'h2};
      tbl[1] = {48'h817400000000, 4'h3, 24'h0, 16'hF0F0, 16'h0, 2'h2};
      tbl[2] = {48'h8A6100000000, 4'h3, 24'h3C2040, 16'hE540, 16'h0, 2'h2};
      tbl[3] = {48'h8A4800000000, 4'h3, 24'h3C1000, 16'h1234, 16'h0, 2'h0};
      tbl[4] = {48'h84E1F0000000, 4'h5, 24'h3C2030, 16'h3030, 16'h0, 2'h0};
      tbl[5] = {48'h8D1812340000, 4'h5, 24'h3C2234, 16'h2040, 16'h0, 2'h0};
      tbl[6] = {48'h866577000000, 4'h4, 24'h000577, 16'h7777, 16'h0, 2'h0};
      tbl[7] = {48'h8E2B00000000, 4'h4, 24'h000300, 16'h80F0, 16'h0, 2'h2};
      tbl[8] = {48'h995800000000, 4'h3, 24'h0, 16'h0000, 16'h0, 2'h1};
      tbl[9] = {48'h920880000000, 4'h3, 24'h3C1000, 16'h0080, 16'h0, 2'h2};
      tbl[10] = {48'h9C0802ABCD00, 4'h5, 24'h3C1002, 16'hABCD, 16'h0, 2'h2};
      tbl[11] = {48'h9418015A0000, 4'h5, 24'h3C2041, 16'h005A, 16'h0, 2'h0};
      tbl[12] = {48'h8B7200000000, 4'h4, 24'h3C80F0, 16'h55F0, 16'h80F2, 2'h0};
      tbl[13] = {48'h839900000000, 4'h4, 24'h3C2040, 16'h0012, 16'h2041, 2'h0};
      tbl[14] = {48'h9B08BEEF0000, 4'h4, 24'h3C1000, 16'hBEEF, 16'h1002, 2'h2};
      tbl[15] = {48'h9638445A0000, 4'h3, 24'h000344, 16'h005A, 16'h0, 2'h0};
      repeat (6) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      // Preload pointers and sources back to back
      preload_en = 1'b1;
      for (i = 0; i < 5; i = i + 1)
      begin
         preload_idx = i;
         preload_data = pre[i];
         @(posedge sys_clk);
         #1;
      end
      preload_en = 1'b0;
      for (i = 0; i < 16; i = i + 1)
      begin
         t = tbl[i];
         run(t[109:62]);
         if (i == 1)
            `CHK(g_w, 6'h0E);
         `CHK(g_n, t[61:58]);
         `CHK(g_a, t[57:34]);
         `CHK(g_d, t[33:18]);
         if (t[17:2] != 16'h0)
            `CHK(g_p, t[17:2]);
         `CHK({neg_flag_q, zero_flag_q}, t[1:0]);
      end
      $display("table test done");
      // Unsupported forms: mode 7, immediate destination, untagged immediate mode 0
      for (i = 0; i < 3; i = i + 1)
      begin
         fl = {neg_flag_q, zero_flag_q};
         run(i == 0 ? 48'h870000000000 : i == 1 ? 48'h928800000000
            : 48'h900000000000);
         `CHK(g_ill, 1'b1);
         `CHK(g_n, 4'h3);
         `CHK(g_a, 24'h0);
         `CHK({neg_flag_q, zero_flag_q}, fl);
      end
      $display("illegal test done");
      // Reset in mid-move, then registers read back as zero
      @(posedge sys_clk);
      #1;
      `CHK(ready_q, 1'b1);
      instr = 48'h9C0802ABCD00;
      instr_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      instr_valid = 1'b0;
      @(posedge sys_clk);
      #1;
      nrst = 1'b0;
      #1;
      `CHK(ready_q, 1'b1);
      `CHK({done_q, mem_wr_q, illegal_q}, 3'h0);
      @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      run(48'h895200000000);
      `CHK(g_d, 16'h0000);
      `CHK({neg_flag_q, zero_flag_q}, 2'h1);
      $display("reset test done");
      finish_test;
   end
endmodule
